// >>> spmc_map.vh
// Register map, field positions and reset values of the serial port mode control block
`ifndef SPMC_MAP_VH
`define SPMC_MAP_VH
`define SPMC_ADDR_MODE 4'h0
`define SPMC_ADDR_STATUS 4'h1
`define SPMC_ADDR_MASK 4'h2
`define SPMC_ADDR_RATE 4'h3
`define SPMC_BIT_PORT_ON 15
`define SPMC_BIT_IDLE_HALT 13
`define SPMC_BIT_IR_ON 12
`define SPMC_BIT_REQ_MODE 11
`define SPMC_BIT_PIN_HI 9
`define SPMC_BIT_PIN_LO 8
`define SPMC_BIT_WAKE 7
`define SPMC_BIT_ECHO 6
`define SPMC_BIT_RATE 5
`define SPMC_BIT_RX_INV 4
`define SPMC_BIT_HS_RATE 3
`define SPMC_MODE_WMASK 16'hBBFF
`define SPMC_MODE_RESET 16'h0000
`define SPMC_PINS_NONE 2'h0
`define SPMC_PINS_RTS 2'h1
`define SPMC_PINS_FLOW 2'h2
`define SPMC_PINS_BCLK 2'h3
`define SPMC_EV_WAKE 0
`define SPMC_EV_RATE_DONE 1
`define SPMC_EV_WIDTH 2
`define SPMC_RATE_EDGES 4'h8
`define SPMC_SYNC_FALLS 4'h4
`endif

// >>> spmc_rate_meter.v
// Measures the bit period from a 0x55 sync character
`timescale 1ns/10ps
`default_nettype none
`include "spmc_map.vh"
module spmc_rate_meter (
    input wire sys_clk,
    input wire rst,
    input wire start,
    input wire rx_in,
    output reg busy,
    output reg done,
    output reg [15:0] period
);
    reg rx_prev;
    reg [3:0] edges;
    reg [19:0] count;
    wire fall = rx_prev & ~rx_in;
    // Fifth fall lands on the count that closes the eighth bit time
    wire [19:0] count_next = count + 20'h00001;
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_prev <= 1'b1;
            edges <= 4'h0;
            count <= 20'h00000;
            busy <= 1'b0;
            done <= 1'b0;
            period <= 16'h0000;
        end else begin
            rx_prev <= rx_in;
            done <= 1'b0;
            if (!busy) begin
                // Enable is still seen in the done cycle; no second start
                if (start && !done) begin
                    busy <= 1'b1;
                    edges <= 4'h0;
                    count <= 20'h00000;
                end
            end else begin
                if (edges != 4'h0)
                    count <= count_next;
                if (fall) begin
                    // Start edge to fifth falling edge spans eight bit times
                    if (edges == `SPMC_SYNC_FALLS) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        period <= count_next[18:3];
                    end
                    edges <= edges + 4'h1;
                end
                if (!start)
                    busy <= 1'b0;
            end
        end
    end
endmodule // spmc_rate_meter
`default_nettype wire

// >>> spmc_mode_control.v
// Serial port mode control: mode register, pin ownership, wake, loopback, rate measurement
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "spmc_map.vh"
// Function
// - Port off hands every pin back to the port latches; port on drives the chosen pins.
// - With idle halt set the port stops while the chip is idle, else it keeps running.
// - The infrared codec bit turns the transmit encoder and receive decoder on or off.
// - Request pin mode selects simplex when 1 and flow control when 0.
// - Pin usage 11 adds baud clock, 10 adds CTS and RTS, 01 adds RTS, 00 adds none.
// - With wake set the receive pin is watched in sleep and a falling edge interrupts.
// - After a wake event the wake bit clears itself on the next rising receive edge.
// - Internal echo set puts the port in loopback; cleared restores normal use.
// - Rate measure set times the next character, which must be the 0x55 sync.
// - The rate measure bit clears itself when the measurement completes.
// - Bits 14 and 10 of the mode register read as zero.
module spmc_mode_control (
    input wire sys_clk,
    input wire rst_n,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    output reg irq,
    input wire chip_idle,
    input wire chip_sleep,
    input wire core_tx_data,
    input wire core_rts,
    input wire core_bclk,
    output reg core_rx_data,
    output reg core_cts,
    output reg core_run,
    input wire latch_tx,
    input wire latch_rts,
    output reg tx_pin_out,
    output reg tx_pin_oe,
    input wire rx_pin_in,
    input wire cts_pin_in,
    output reg rts_pin_out,
    output reg rts_pin_oe,
    output reg rts_simplex
);
    reg rst_meta;
    reg rst_sync;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end
    wire rst = ~rst_sync;

    reg [15:0] mode;
    reg [`SPMC_EV_WIDTH-1:0] status;
    reg [`SPMC_EV_WIDTH-1:0] mask;
    reg rx_prev;
    reg wake_seen;
    wire meter_busy;
    wire meter_done;
    wire [15:0] meter_period;

    wire port_on = mode[`SPMC_BIT_PORT_ON];
    wire idle_halt_select = mode[`SPMC_BIT_IDLE_HALT];
    wire infrared_codec_on = mode[`SPMC_BIT_IR_ON];
    wire request_pin_mode = mode[`SPMC_BIT_REQ_MODE];
    wire [1:0] pin_usage_select = mode[`SPMC_BIT_PIN_HI:`SPMC_BIT_PIN_LO];
    wire wake_enable = mode[`SPMC_BIT_WAKE];
    wire internal_echo_select = mode[`SPMC_BIT_ECHO];
    wire rate_measure_enable = mode[`SPMC_BIT_RATE];
    wire receive_polarity_invert = mode[`SPMC_BIT_RX_INV];

    wire wr_mode = reg_wr && reg_addr == `SPMC_ADDR_MODE;
    wire rx_fall = rx_prev & ~rx_pin_in;
    wire rx_rise = ~rx_prev & rx_pin_in;
    wire wake_event = wake_enable && chip_sleep && rx_fall;
    wire wake_clear = wake_enable && wake_seen && rx_rise;

    // Infrared: pulse low for a short slot, here modelled as the inverted level
    wire tx_coded = infrared_codec_on ? ~core_tx_data : core_tx_data;
    wire rx_level = receive_polarity_invert ? ~rx_pin_in : rx_pin_in;
    wire rx_decoded = infrared_codec_on ? ~rx_level : rx_level;
    wire rx_path = internal_echo_select ? core_tx_data : rx_decoded;
    wire running = port_on && !(idle_halt_select && chip_idle);

    wire [15:0] mode_read = mode & `SPMC_MODE_WMASK;
    reg [`SPMC_EV_WIDTH-1:0] events;
    always @* begin
        events = {`SPMC_EV_WIDTH{1'b0}};
        events[`SPMC_EV_WAKE] = wake_event;
        events[`SPMC_EV_RATE_DONE] = meter_done;
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mode <= `SPMC_MODE_RESET;
            rx_prev <= 1'b1;
            wake_seen <= 1'b0;
        end else begin
            rx_prev <= rx_pin_in;
            if (wr_mode)
                mode <= reg_wdata & `SPMC_MODE_WMASK;
            // Hardware clears win over a same-cycle write only for their own bit
            if (wake_clear) begin
                mode[`SPMC_BIT_WAKE] <= 1'b0;
                wake_seen <= 1'b0;
            end else if (wake_event) begin
                wake_seen <= 1'b1;
            end else if (!wake_enable) begin
                // Software abort must not leave a pending clear behind
                wake_seen <= 1'b0;
            end
            if (meter_done)
                mode[`SPMC_BIT_RATE] <= 1'b0;
        end
    end

    spmc_rate_meter u_meter (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(rate_measure_enable && running),
        .rx_in(rx_path),
        .busy(meter_busy),
        .done(meter_done),
        .period(meter_period)
    );

    // Status: set wins over the read clear
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            status <= {`SPMC_EV_WIDTH{1'b0}};
            mask <= {`SPMC_EV_WIDTH{1'b0}};
            irq <= 1'b0;
        end else begin
            if (reg_rd && reg_addr == `SPMC_ADDR_STATUS)
                status <= events;
            else
                status <= status | events;
            if (reg_wr && reg_addr == `SPMC_ADDR_MASK)
                mask <= reg_wdata[`SPMC_EV_WIDTH-1:0];
            irq <= |((status | events) & mask);
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `SPMC_ADDR_MODE: reg_rdata <= mode_read;
                `SPMC_ADDR_STATUS: reg_rdata <= {14'h0, status};
                `SPMC_ADDR_MASK: reg_rdata <= {14'h0, mask};
                `SPMC_ADDR_RATE: reg_rdata <= meter_period;
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // Pin ownership; disabled port leaves every pin to the latches
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_pin_out <= 1'b1;
            tx_pin_oe <= 1'b0;
            rts_pin_out <= 1'b1;
            rts_pin_oe <= 1'b0;
            rts_simplex <= 1'b0;
            core_rx_data <= 1'b1;
            core_cts <= 1'b0;
            core_run <= 1'b0;
        end else begin
            core_run <= running && !meter_busy;
            rts_simplex <= request_pin_mode;
            core_rx_data <= port_on ? rx_path : 1'b1;
            if (!port_on) begin
                tx_pin_out <= latch_tx;
                tx_pin_oe <= 1'b1;
                rts_pin_out <= latch_rts;
                rts_pin_oe <= 1'b1;
                core_cts <= 1'b0;
            end else begin
                // Loopback keeps the line idle so the far end sees nothing
                tx_pin_out <= internal_echo_select ? 1'b1 : tx_coded;
                tx_pin_oe <= 1'b1;
                case (pin_usage_select)
                    `SPMC_PINS_BCLK: begin
                        rts_pin_out <= core_bclk;
                        rts_pin_oe <= 1'b1;
                        core_cts <= 1'b0;
                    end
                    `SPMC_PINS_FLOW: begin
                        rts_pin_out <= core_rts;
                        rts_pin_oe <= 1'b1;
                        core_cts <= cts_pin_in;
                    end
                    `SPMC_PINS_RTS: begin
                        rts_pin_out <= core_rts;
                        rts_pin_oe <= 1'b1;
                        core_cts <= 1'b0;
                    end
                    default: begin
                        rts_pin_out <= latch_rts;
                        rts_pin_oe <= 1'b1;
                        core_cts <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // spmc_mode_control
`default_nettype wire

// >>> spmc_mode_control_sva.sv
// Assertion checker for the serial port mode control block
`timescale 1ns/10ps
`default_nettype none
`include "spmc_map.vh"
module spmc_mode_control_sva (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic chip_idle,
    input wire logic core_tx_data,
    input wire logic core_rts,
    input wire logic core_bclk,
    input wire logic core_rx_data,
    input wire logic core_cts,
    input wire logic core_run,
    input wire logic latch_tx,
    input wire logic latch_rts,
    input wire logic tx_pin_out,
    input wire logic cts_pin_in,
    input wire logic rts_pin_out,
    input wire logic rts_simplex
);
    // Mirror tracks software writes; checks use only bits that hardware never clears
    logic [15:0] m;
    logic [2:0] sh;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            m <= 16'h0000;
            sh <= 3'h0;
        end else begin
            sh <= {sh[1:0], 1'b1};
            if (reg_wr && reg_addr == `SPMC_ADDR_MODE)
                m <= reg_wdata & `SPMC_MODE_WMASK;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence mode_read;
        reg_rd && reg_addr == `SPMC_ADDR_MODE;
    endsequence
    chk_mode_resv: assert property (mode_read |=> !reg_rdata[14] && !reg_rdata[10])
        else $error("reserved mode bit set");
    chk_port_off: assert property (sh[2] && $past(!m[15]) |->
        tx_pin_out == $past(latch_tx) && rts_pin_out == $past(latch_rts))
        else $error("pins not on latches");
    chk_tx_follow: assert property (sh[2] && $past(m[15:12] == 4'h8 && !m[6]) |->
        tx_pin_out == $past(core_tx_data))
        else $error("transmit pin not driven");
    chk_rts_pin: assert property (sh[2] && $past(m[15] && !m[13]) |-> rts_pin_out ==
        $past(m[9:8] == 2'h0 ? latch_rts : m[9:8] == 2'h3 ? core_bclk : core_rts))
        else $error("request pin owner wrong");
    chk_cts_follow: assert property (sh[2] && $past(m[15] && m[9:8] == 2'h2) |->
        core_cts == $past(cts_pin_in))
        else $error("clear to send not passed");
    chk_rts_mode: assert property (sh[2] |-> rts_simplex == $past(m[11]))
        else $error("request mode wrong");
    chk_loop_rx: assert property (sh[2] &&
        $past(m[15:12] == 4'h8 && m[6] && !m[4]) |->
        core_rx_data == $past(core_tx_data) && tx_pin_out)
        else $error("loopback path wrong");
    chk_idle_halt: assert property (sh[2] && $past(!m[15] || m[13] && chip_idle) |->
        !core_run)
        else $error("port runs while halted");
endmodule // spmc_mode_control_sva
bind spmc_mode_control spmc_mode_control_sva sva (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chip_idle(chip_idle),
    .core_tx_data(core_tx_data), .core_rts(core_rts), .core_bclk(core_bclk),
    .core_rx_data(core_rx_data), .core_cts(core_cts), .core_run(core_run),
    .latch_tx(latch_tx), .latch_rts(latch_rts), .tx_pin_out(tx_pin_out),
    .cts_pin_in(cts_pin_in), .rts_pin_out(rts_pin_out), .rts_simplex(rts_simplex));
`default_nettype wire

// >>> spmc_serial_peer.sv
// Remote serial sender facing the receive and clear-to-send pins
`timescale 1ns/10ps
`default_nettype none
module spmc_serial_peer (
    input wire logic sys_clk,
    output logic rx_line,
    output logic cts_line
);
    initial begin
        rx_line = 1'b1;
        cts_line = 1'b1;
    end
    // Frame LSB first; line rests high after the stop bit
    task automatic send(input logic [7:0] b, input int bt);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge sys_clk);
            rx_line <= f[i];
            repeat (bt - 1) @(posedge sys_clk);
        end
    endtask
    task automatic ready(input logic v);
        @(posedge sys_clk);
        cts_line <= v;
    endtask
endmodule // spmc_serial_peer
`default_nettype wire

// >>> spmc_mode_control_tb_top.sv
// Self-checking testbench for the serial port mode control block
`timescale 1ns/10ps
`default_nettype none
module spmc_mode_control_tb_top;
    logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic chip_idle = 1'b0, chip_sleep = 1'b0, rx, cts;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [4:0] cnt = 5'h00;
    wire [15:0] reg_rdata;
    wire irq, core_rx_data, core_cts, core_run, tx_pin_out, rts_pin_out, rts_simplex;
    wire tx_oe, rts_oe;
    int err_total = 0;
    int checks = 0;
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cnt <= cnt + 5'h01;
    spmc_serial_peer peer (.sys_clk(sys_clk), .rx_line(rx), .cts_line(cts));
    spmc_mode_control DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .chip_idle(chip_idle), .chip_sleep(chip_sleep), .core_tx_data(cnt[0]),
        .core_rts(cnt[1]), .core_bclk(cnt[2]), .core_rx_data(core_rx_data),
        .core_cts(core_cts), .core_run(core_run), .latch_tx(cnt[3]), .latch_rts(cnt[4]),
        .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_oe), .rx_pin_in(rx), .cts_pin_in(cts),
        .rts_pin_out(rts_pin_out), .rts_pin_oe(rts_oe), .rts_simplex(rts_simplex));
    task chk(input logic ok, input string what);
        checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk((reg_rdata & m) === e, "register read");
    endtask
    task summarize;
        $display("Counts: %0d checks, %0d mismatches", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        chk(tx_oe === 1'b0 && rts_oe === 1'b0, "pins released in reset");
        chk(irq === 1'b0 && core_run === 1'b0, "outputs idle in reset");
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(4'h0, 16'hFFFF, 16'h0000);
        wr(4'hF, 16'hFFFF);
        rd(4'hF, 16'hFFFF, 16'h0000);
        wr(4'h0, 16'hFFF7);
        rd(4'h0, 16'hFFFF, 16'hBBF7);
        $display("test register map done");
        for (int u = 0; u < 4; u++) begin
            peer.ready(u == 2);
            wr(4'h0, {6'h20, u[1:0], 8'h00});
            repeat (6) @(posedge sys_clk);
            chk(core_cts === (u == 2), "clear to send routing");
        end
        wr(4'h0, 16'h8040);
        repeat (4) @(posedge sys_clk);
        chk(tx_pin_out === 1'b1, "echo leaves pin idle");
        chk(tx_oe === 1'b1 && rts_oe === 1'b1, "pins driven when on");
        wr(4'h0, 16'hA000);
        chip_idle <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk(core_run === 1'b0, "halted in idle");
        chip_idle <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk(core_run === 1'b1, "resumes after idle");
        wr(4'h0, 16'h9000);
        repeat (4) @(posedge sys_clk);
        chk(core_rx_data === 1'b0, "decoder inverts");
        wr(4'h0, 16'h8000);
        repeat (4) @(posedge sys_clk);
        chk(core_rx_data === 1'b1, "decoder off");
        $display("test pins done");
        wr(4'h2, 16'h0003);
        wr(4'h0, 16'h8080);
        chip_sleep <= 1'b1;
        peer.send(8'hFF, 4);
        chk(irq === 1'b1, "wake interrupt");
        rd(4'h1, 16'h0003, 16'h0001);
        repeat (2) @(posedge sys_clk);
        chk(irq === 1'b0, "status read clears");
        rd(4'h0, 16'h0080, 16'h0000);
        chip_sleep <= 1'b0;
        wr(4'h2, 16'h0000);
        wr(4'h0, 16'h8020);
        peer.send(8'h55, 6);
        repeat (4) @(posedge sys_clk);
        rd(4'h0, 16'h0020, 16'h0000);
        chk(irq === 1'b0, "masked event");
        rd(4'h1, 16'h0003, 16'h0002);
        rd(4'h3, 16'hFFFF, 16'h0006);
        $display("test events done");
        summarize;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        summarize;
    end
endmodule // spmc_mode_control_tb_top
`default_nettype wire
